// ==== shared/spc_pkg.sv ====
// spc_pkg: constants and types of the serial port control block
package spc_pkg;
    // ==========================================
    // register addresses
    localparam logic [7:0] SPC_ADDR_RATE = 8'hA2;
    localparam logic [7:0] SPC_ADDR_DATA = 8'hA3;
    localparam logic [7:0] SPC_ADDR_CTL = 8'hF8;
    // bit addresses of the control register share these upper five bits
    localparam logic [4:0] SPC_BIT_BASE = 5'h1F;
    // ==========================================
    // control register bit positions
    localparam int SPC_B_DONE = 7;
    localparam int SPC_B_WRITE_COLLISION_FLAG = 6;
    localparam int SPC_B_MODE_FAULT_FLAG = 5;
    localparam int SPC_B_OVR = 4;
    localparam int SPC_B_WIRE_HI = 3;
    localparam int SPC_B_WIRE_LO = 2;
    localparam int SPC_B_TXE = 1;
    localparam int SPC_B_EN = 0;
    // ==========================================
    // wiring modes
    localparam logic [1:0] SPC_WIRE_3 = 2'h0;
    localparam logic [1:0] SPC_WIRE_4IN = 2'h1;
    // ==========================================
    // reset values and counts
    localparam logic [7:0] SPC_CTL_RST = 8'h06;
    localparam logic [7:0] SPC_RATE_RST = 8'h00;
    localparam logic [7:0] SPC_DATA_RST = 8'h00;
    localparam logic [3:0] SPC_BITS = 4'h8;
    // ==========================================
    // control register layout
    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic receive_overrun_flag;
        logic [1:0] select_wiring_mode;
        logic tx_buffer_empty;
        logic serial_port_enable;
    } spc_ctl_t;
endpackage : spc_pkg

// ==== src/spc_ctrl.sv ====
// spc_ctrl: serial port control, status, clock rate and byte engine
`timescale 1ns/1ps
`default_nettype none
// Contract
// - set transfer done at end of each transfer; only software clears it.
// - data write during a transfer sets write collision; software clears it.
// - select low, master, wiring 01 sets mode fault; software clears it.
// - slave only: unread receive data at final bit sets receive overrun.
// - wiring 00: three-wire operation, select pin neither used nor driven.
// - wiring 01, reset default: select is an input, four-wire slave/multi-master.
// - wiring 1x: select driven out at the lower wiring bit.
// - tx empty clears on data write, sets when byte moves to shifter.
// - enable bit 0 disables the port, 1 enables; resets to 0.
// - master serial clock is system clock over 2*(rate+1).
// - control register bit-addressable; single-bit writes touch one bit, except tx empty, which ignores them.
// - master role enable 0 means slave, 1 means master.
// - data write loads tx buffer, starts master transfer; read returns rx.
module spc_ctrl
    import spc_pkg::*;
#(
    parameter int RATE_W = 8,
    parameter int RX_DEPTH = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic bit_wr,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    output logic [7:0] sfr_rdata,
    output logic irq,
    input wire logic master_role_enable,
    input wire logic clk_polarity,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic nss_in,
    output logic nss_out,
    output logic nss_oe
);
    localparam int PW = $clog2(RX_DEPTH);

    // ==========================================
    // state
    spc_ctl_t ctl_q, ctl_d;
    logic [RATE_W-1:0] rate_q, rate_d, div_q, div_d;
    logic [7:0] txbuf_q, txbuf_d, shift_q, shift_d;
    logic [7:0] rxmem_q [RX_DEPTH];
    logic [7:0] rx_wdata;
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [PW:0] cnt_q, cnt_d;
    logic [3:0] bits_q, bits_d;
    logic busy_q, busy_d, smp_q, smp_d, sck_q, sck_d, sckp_q, sck_pin_q;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d, push, pop;
    logic sck_oe_q, mosi_q, mosi_oe_q, miso_q, miso_oe_q, nss_q, nss_oe_q;

    function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
        nxt = (p == PW'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : nxt

    // ==========================================
    // decode
    logic wr_ctl, wr_rate, wr_data, rd_data, bit_hit;
    logic mst, sel, lead, trail, rx_ready, rx_valid, wire3;
    always_comb begin
        wr_ctl = sfr_wr && sfr_addr == SPC_ADDR_CTL;
        wr_rate = sfr_wr && sfr_addr == SPC_ADDR_RATE;
        wr_data = sfr_wr && sfr_addr == SPC_ADDR_DATA;
        rd_data = sfr_rd && sfr_addr == SPC_ADDR_DATA;
        bit_hit = bit_wr && bit_addr[7:3] == SPC_BIT_BASE;
        wire3 = ctl_q.select_wiring_mode == SPC_WIRE_3;
        mst = ctl_q.serial_port_enable && master_role_enable;
        // 3-wire slave is always selected; 4-wire needs select low
        sel = ctl_q.serial_port_enable && !master_role_enable
            && !ctl_q.select_wiring_mode[1] && (wire3 || !nss_in);
        lead = sel && (sckp_q == clk_polarity) && (sck_in != clk_polarity);
        trail = sel && (sckp_q != clk_polarity) && (sck_in == clk_polarity);
        rx_valid = cnt_q != '0;
        // master waits for room so no received word is lost
        rx_ready = cnt_q != (PW+1)'(RX_DEPTH);
    end

    // ==========================================
    // next state
    logic done;
    always_comb begin
        ctl_d = ctl_q;
        rate_d = rate_q;
        txbuf_d = txbuf_q;
        shift_d = shift_q;
        div_d = div_q;
        bits_d = bits_q;
        busy_d = busy_q;
        smp_d = smp_q;
        sck_d = sck_q;
        done = 1'b0;
        push = 1'b0;
        rx_wdata = shift_q;
        // software writes: write 0 clears a flag
        if (wr_ctl) begin
            ctl_d.transfer_done_flag = sfr_wdata[SPC_B_DONE];
            ctl_d.write_collision_flag = sfr_wdata[SPC_B_WRITE_COLLISION_FLAG];
            ctl_d.mode_fault_flag = sfr_wdata[SPC_B_MODE_FAULT_FLAG];
            ctl_d.receive_overrun_flag = sfr_wdata[SPC_B_OVR];
            ctl_d.select_wiring_mode = sfr_wdata[SPC_B_WIRE_HI:SPC_B_WIRE_LO];
            ctl_d.serial_port_enable = sfr_wdata[SPC_B_EN];
        end
        if (bit_hit && bit_addr[2:0] != 3'(SPC_B_TXE)) begin
            ctl_d[bit_addr[2:0]] = bit_wdata;
        end
        if (wr_rate) begin
            rate_d = sfr_wdata[RATE_W-1:0];
        end
        if (wr_data) begin
            if (busy_q) begin
                ctl_d.write_collision_flag = 1'b1;
            end else begin
                txbuf_d = sfr_wdata;
                ctl_d.tx_buffer_empty = 1'b0;
            end
        end
        // master engine
        if (mst) begin
            if (!busy_q) begin
                sck_d = 1'b0;
                if (!ctl_q.tx_buffer_empty && rx_ready) begin
                    shift_d = txbuf_q;
                    // a data write in this same cycle refills the buffer
                    ctl_d.tx_buffer_empty = !wr_data;
                    busy_d = 1'b1;
                    div_d = '0;
                    bits_d = '0;
                end
            end else if (div_q == rate_q) begin
                div_d = '0;
                sck_d = !sck_q;
                if (!sck_q) begin
                    smp_d = miso_in;
                end else begin
                    shift_d = {shift_q[6:0], smp_q};
                    bits_d = bits_q + 1'b1;
                    if (bits_q == SPC_BITS - 1'b1) begin
                        done = 1'b1;
                        rx_wdata = {shift_q[6:0], smp_q};
                    end
                end
            end else begin
                div_d = div_q + 1'b1;
            end
        end else if (sel) begin
            if (!busy_q) begin
                bits_d = '0;
                // idle slave keeps the next byte on the pin until the first edge
                shift_d = ctl_q.tx_buffer_empty ? SPC_DATA_RST : txbuf_q;
                if (lead) begin
                    busy_d = 1'b1;
                    smp_d = mosi_in;
                    if (!ctl_q.tx_buffer_empty) begin
                        ctl_d.tx_buffer_empty = !wr_data;
                    end
                end
            end else if (lead) begin
                smp_d = mosi_in;
            end else if (trail) begin
                shift_d = {shift_q[6:0], smp_q};
                bits_d = bits_q + 1'b1;
                if (bits_q == SPC_BITS - 1'b1) begin
                    done = 1'b1;
                    rx_wdata = {shift_q[6:0], smp_q};
                    if (rx_valid) begin
                        ctl_d.receive_overrun_flag = 1'b1;
                    end
                end
            end
        end else begin
            // disabled or deselected: abandon any partial byte
            busy_d = 1'b0;
            sck_d = 1'b0;
        end
        if (done) begin
            busy_d = 1'b0;
            push = rx_ready;
            ctl_d.transfer_done_flag = 1'b1;
        end
        if (ctl_q.serial_port_enable && master_role_enable && !nss_in
            && ctl_q.select_wiring_mode == SPC_WIRE_4IN) begin
            ctl_d.mode_fault_flag = 1'b1;
        end
    end

    // ==========================================
    // receive buffer and read path
    always_comb begin
        pop = rd_data && rx_valid;
        wp_d = push ? nxt(wp_q) : wp_q;
        rp_d = pop ? nxt(rp_q) : rp_q;
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        rdata_d = 8'h00;
        case (sfr_addr)
            SPC_ADDR_CTL: rdata_d = ctl_q;
            SPC_ADDR_RATE: rdata_d = 8'(rate_q);
            SPC_ADDR_DATA: rdata_d = rxmem_q[rp_q];
            default: rdata_d = 8'h00;
        endcase
        if (!sfr_rd) begin
            rdata_d = rdata_q;
        end
        irq_d = ctl_q.transfer_done_flag || ctl_q.write_collision_flag
            || ctl_q.mode_fault_flag || ctl_q.receive_overrun_flag;
    end

    // ==========================================
    // registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_q <= SPC_CTL_RST;
            rate_q <= RATE_W'(SPC_RATE_RST);
            txbuf_q <= SPC_DATA_RST;
            shift_q <= SPC_DATA_RST;
            div_q <= '0;
            bits_q <= '0;
            busy_q <= 1'b0;
            smp_q <= 1'b0;
            sck_q <= 1'b0;
            sckp_q <= clk_polarity;
            sck_pin_q <= clk_polarity;
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            sck_oe_q <= 1'b0;
            mosi_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
            nss_q <= 1'b0;
            nss_oe_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            rate_q <= rate_d;
            txbuf_q <= txbuf_d;
            shift_q <= shift_d;
            div_q <= div_d;
            bits_q <= bits_d;
            busy_q <= busy_d;
            smp_q <= smp_d;
            sck_q <= sck_d;
            sckp_q <= sck_in;
            sck_pin_q <= sck_d ^ clk_polarity;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            sck_oe_q <= mst;
            mosi_q <= shift_d[7];
            mosi_oe_q <= mst;
            miso_q <= shift_d[7];
            miso_oe_q <= sel;
            nss_q <= ctl_d.select_wiring_mode[0];
            nss_oe_q <= ctl_d.serial_port_enable && ctl_d.select_wiring_mode[1];
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            rxmem_q[wp_q] <= rx_wdata;
        end
    end

    assign sfr_rdata = rdata_q;
    assign irq = irq_q;
    assign sck_out = sck_pin_q;
    assign sck_oe = sck_oe_q;
    assign mosi_out = mosi_q;
    assign mosi_oe = mosi_oe_q;
    assign miso_out = miso_q;
    assign miso_oe = miso_oe_q;
    assign nss_out = nss_q;
    assign nss_oe = nss_oe_q;
endmodule : spc_ctrl
`default_nettype wire

// ==== verification/spc_ctrl_monitor.sv ====
// spc_ctrl_monitor: port assertions for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl_monitor
    import spc_pkg::*;
#(
    parameter int RATE_W = 8,
    parameter int RX_DEPTH = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic bit_wr,
    input wire logic irq,
    input wire logic master_role_enable,
    input wire logic nss_in,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic nss_out,
    input wire logic nss_oe
);
    // ==========
    // shadow state
    // byte writes only: bits 3, 2 and 0 are never bit-written by the bench
    logic [7:0] rate_q;
    logic en_q;
    logic [1:0] wire_q;
    logic sck_p_q;
    logic [8:0] gap_q;
    logic drv_sel;
    logic sw_wr;
    assign drv_sel = en_q & wire_q[1];
    assign sw_wr = sfr_wr | bit_wr;
    always_ff @(posedge clk) begin
        sck_p_q <= sck_out;
        if (!resetn) begin
            rate_q <= SPC_RATE_RST;
            en_q <= 1'b0;
            wire_q <= SPC_WIRE_4IN;
            gap_q <= 9'h000;
        end else begin
            gap_q <= (sck_out != sck_p_q) ? 9'h000 : gap_q + {8'h00, gap_q != 9'h1FF};
            if (sfr_wr && sfr_addr == SPC_ADDR_RATE) begin
                rate_q <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == SPC_ADDR_CTL) begin
                en_q <= sfr_wdata[SPC_B_EN];
                wire_q <= sfr_wdata[SPC_B_WIRE_HI:SPC_B_WIRE_LO];
            end
        end
    end
    // ==========
    // assertions
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence fault_s;
        en_q && master_role_enable && wire_q == SPC_WIRE_4IN && !nss_in;
    endsequence
    sequence toggle_s;
        sck_oe && sck_out != sck_p_q;
    endsequence
    off_quiet_a: assert property ($past(!en_q) && !en_q |-> !(sck_oe || mosi_oe || nss_oe))
        else $error("pins driven while disabled");
    sel_in_a: assert property ($past(!wire_q[1]) && !wire_q[1] |-> !nss_oe)
        else $error("select driven in input wiring");
    sel_out_a: assert property ($past(drv_sel) && drv_sel && $stable(wire_q)
        |-> nss_oe && nss_out == wire_q[0]) else $error("select output wrong");
    flag_hold_a: assert property ($fell(irq) |-> $past(sw_wr) || $past(sw_wr, 2))
        else $error("irq dropped without software write");
    oe_pair_a: assert property (mosi_oe == sck_oe)
        else $error("data and clock enables differ");
    slave_role_a: assert property ($past(!master_role_enable) && !master_role_enable |-> !sck_oe)
        else $error("clock driven in slave role");
    half_period_a: assert property (toggle_s |-> gap_q >= {1'b0, rate_q})
        else $error("serial clock half period too short");
    mode_fault_a: assert property (fault_s |-> ##[1:2] irq)
        else $error("mode fault did not raise irq");
    role_excl_a: assert property (!(sck_oe && miso_oe))
        else $error("master and slave outputs both enabled");
endmodule : spc_ctrl_monitor
bind spc_ctrl spc_ctrl_monitor #(.RATE_W(RATE_W), .RX_DEPTH(RX_DEPTH)) spc_ctrl_monitor_inst (
    .clk, .resetn, .sfr_addr, .sfr_wr, .sfr_wdata, .bit_wr, .irq, .master_role_enable,
    .nss_in, .sck_out, .sck_oe, .mosi_oe, .miso_oe, .nss_out, .nss_oe);
`default_nettype wire

// ==== verification/spc_slave_model.sv ====
// spc_slave_model: external serial slave answering master transfers
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
    input wire logic clk,
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    // ==========
    // shifter
    logic sck_q = 1'b0;
    logic flip_q = 1'b0;
    logic [7:0] sh_q = 8'h00;
    // released line toggles so a stale bit never reads as valid
    assign miso = sel_n ? flip_q : sh_q[7];
    always @(posedge clk) begin
        sck_q <= sck;
        flip_q <= ~flip_q;
        if (sel_n) begin
            sh_q <= tx_byte;
        end else if (sck && !sck_q) begin
            rx_byte <= {rx_byte[6:0], mosi};
        end else if (!sck && sck_q) begin
            sh_q <= {sh_q[6:0], 1'b0};
        end
    end
endmodule : spc_slave_model
`default_nettype wire

// ==== verification/tb_spc_ctrl.sv ====
// tb_spc_ctrl: register-level tests of the serial port control block
`timescale 1ns/1ps
`default_nettype none
module tb_spc_ctrl;
    import spc_pkg::*;
    // ==========
    // stimulus and hookup
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] bit_addr = 8'h00;
    logic [7:0] sl_tx = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic bit_wr = 1'b0;
    logic bit_wdata = 1'b0;
    logic master = 1'b1;
    logic nss_in = 1'b1;
    logic sl_sck = 1'b0;
    logic sl_mosi = 1'b0;
    logic [7:0] sfr_rdata, sl_rx, r, got;
    logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_in, nss_out, nss_oe, miso_out, miso_oe;
    int n_fail = 0;
    int cmp_count = 0;
    int h;
    always #12.5 clk = ~clk;
    spc_ctrl spc_ctrl_inst (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .bit_wr,
        .bit_addr, .bit_wdata, .sfr_rdata, .irq, .master_role_enable(master),
        .clk_polarity(1'b0), .sck_in(sl_sck), .sck_out, .sck_oe, .mosi_in(sl_mosi), .mosi_out,
        .mosi_oe, .miso_in, .miso_out, .miso_oe, .nss_in, .nss_out, .nss_oe);
    spc_slave_model spc_slave_model_inst (.clk, .sck(sck_out), .mosi(mosi_out),
        .sel_n(!nss_oe || nss_out), .tx_byte(sl_tx), .miso(miso_in), .rx_byte(sl_rx));
    // ==========
    // tasks
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk(sfr_rdata, e);
    endtask : rdc
    task automatic bw(input logic [2:0] b, input logic v);
        @(negedge clk);
        bit_addr = {SPC_BIT_BASE, b};
        bit_wdata = v;
        bit_wr = 1'b1;
        @(negedge clk);
        bit_wr = 1'b0;
    endtask : bw
    // bench as serial master: four cycles low, three high, slave output taken before the rise
    task automatic sl_byte(input logic [7:0] d, output logic [7:0] q);
        q = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            @(negedge clk);
            sl_mosi = d[b];
            repeat (3) @(negedge clk);
            q = {q[6:0], miso_out};
            sl_sck = 1'b1;
            repeat (3) @(negedge clk);
            sl_sck = 1'b0;
        end
        @(negedge clk);
    endtask : sl_byte
    // bounded waits: a hang ends the run as a failure
    task automatic wait_irq(input logic lvl);
        for (int k = 0; irq !== lvl; k++) begin
            if (k > 9000) begin
                n_fail++;
                stop_test();
            end
            @(negedge clk);
        end
    endtask : wait_irq
    task automatic edge_wait();
        logic s;
        s = sck_out;
        for (h = 0; sck_out === s; h++) begin
            if (h > 600) begin
                n_fail++;
                stop_test();
            end
            @(negedge clk);
        end
    endtask : edge_wait
    // ==========
    // tests
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        rdc(SPC_ADDR_CTL, SPC_CTL_RST);
        rdc(SPC_ADDR_RATE, 8'h00);
        rdc(8'h55, 8'h00);
        $display("test reset done");
        wr(SPC_ADDR_CTL, 8'h04);
        rdc(SPC_ADDR_CTL, 8'h06);
        bw(3'(SPC_B_TXE), 1'b0);
        rdc(SPC_ADDR_CTL, 8'h06);
        bw(3'(SPC_B_DONE), 1'b1);
        wait_irq(1'b1);
        rdc(SPC_ADDR_CTL, 8'h86);
        bw(3'(SPC_B_DONE), 1'b0);
        wait_irq(1'b0);
        $display("test flags done");
        wr(SPC_ADDR_CTL, 8'h05);
        nss_in = 1'b0;
        wait_irq(1'b1);
        nss_in = 1'b1;
        rdc(SPC_ADDR_CTL, 8'h27);
        $display("test fault done");
        for (int i = 0; i < 2; i++) begin
            r = i ? 8'hFF : 8'h01;
            wr(SPC_ADDR_RATE, r);
            rdc(SPC_ADDR_RATE, r);
            sl_tx = 8'hC3 ^ r;
            wr(SPC_ADDR_CTL, 8'h0F);
            wr(SPC_ADDR_CTL, 8'h0B);
            wr(SPC_ADDR_DATA, 8'h5A ^ r);
            wr(SPC_ADDR_DATA, 8'h11);
            edge_wait();
            edge_wait();
            chk(8'(h - 1), r);
            rdc(SPC_ADDR_CTL, 8'h4B);
            bw(3'(SPC_B_WRITE_COLLISION_FLAG), 1'b0);
            wait_irq(1'b0);
            wait_irq(1'b1);
            rdc(SPC_ADDR_CTL, 8'h8B);
            rdc(SPC_ADDR_DATA, 8'hC3 ^ r);
            chk(sl_rx, 8'h5A ^ r);
            $display("test transfer done");
        end
        for (int w = 0; w < 4; w++) begin
            wr(SPC_ADDR_CTL, {4'h0, 2'(w), 2'b01});
            repeat (2) @(negedge clk);
            chk({6'h00, nss_oe, nss_oe & nss_out}, {6'h00, 1'(w >> 1), 1'(w == 3)});
        end
        $display("test wiring done");
        master = 1'b0;
        wr(SPC_ADDR_CTL, 8'h01);
        repeat (2) @(negedge clk);
        chk({6'h00, sck_oe, miso_oe}, 8'h01);
        wr(SPC_ADDR_DATA, 8'h69);
        sl_byte(8'h96, got);
        chk(got, 8'h69);
        sl_byte(8'h3C, got);
        chk(got, SPC_DATA_RST);
        rdc(SPC_ADDR_CTL, 8'h93);
        rdc(SPC_ADDR_DATA, 8'h96);
        rdc(SPC_ADDR_DATA, 8'h3C);
        $display("test slave done");
        wr(SPC_ADDR_CTL, 8'h00);
        repeat (2) @(negedge clk);
        chk({4'h0, miso_oe, sck_oe, mosi_oe, nss_oe}, 8'h00);
        $display("test enable done");
        stop_test();
    end
endmodule : tb_spc_ctrl
`default_nettype wire
